//--- logic/dsr_pkg.sv
// shared constants and carrier types for the separate-io burst sram block
package dsr_pkg;
    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int DATA_W = 18;
    localparam int BURST_LEN = 2;
    localparam int MEM_DEPTH = 16;
    localparam int IDX_W = 4;

    // ------------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
    localparam logic              RW_READ  = 1'b1;
    localparam logic              PHASE_POS = 1'b0;
    localparam logic              PHASE_NEG = 1'b1;
    localparam logic [1:0]        SYNC_RST = 2'h0;

    // ------------------------------------------------------------------
    // timing: one burst takes one clock period of bus activity
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int BEAT_NS = 25;
    localparam int BEATS_PER_CMD = (CLK_PERIOD_NS + BEAT_NS - 1) / BEAT_NS;
    // cycles after reset release until a pin level has crossed both flops
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    typedef struct packed {
        logic              rd;
        logic [ADDR_W-1:0] addr;
    } dsr_cmd_s;

    typedef struct packed {
        logic [DATA_W-1:0] beat1;
        logic [DATA_W-1:0] beat0;
    } dsr_burst_s;
endpackage

//--- logic/dsr_buf2.sv
// two-entry valid/ready buffer holding whole read bursts
`timescale 1ns/1ps
`default_nettype none
module dsr_buf2 (
    input  wire logic            ref_clk,  // block clock
    input  wire logic            rst_b,    // sync reset, active low
    input  wire logic            in_valid, // word offered
    output logic                 in_ready, // room for a word
    input  wire dsr_pkg::dsr_burst_s in_data, // word in
    output logic                 out_valid, // word held
    input  wire logic            out_ready, // receiver takes word
    output dsr_pkg::dsr_burst_s  out_data   // oldest word
);
    dsr_pkg::dsr_burst_s mem [2];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] count;
    logic       push;
    logic       pop;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            count <= 2'h0;
        end else if (push && !pop) begin
            count <= count + 2'h1;
        end else if (pop && !push) begin
            count <= count - 2'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) mem[wr_ptr] <= in_data;
    end
endmodule // dsr_buf2
`default_nettype wire

//--- logic/dsr_core.sv
// clock and command control of a separate-io double-rate burst sram
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RQ1] with the load strobe low, read/write select high means read and low means write at that address.
// [RQ2] each load moves exactly two words, one clock period of bus activity.
// [RQ3] accesses start only on a rising edge of the positive input clock.
// [RQ4] inputs are sampled on the positive input clock, which also launches data in single clock mode.
// [RQ5] inputs are also sampled on the negative input clock, which launches the second beat in single clock mode.
// [RQ6] read data leaves on the positive and negative output clocks, one beat each.
// [RQ7] the positive echo clock follows the positive output clock, or the positive input clock in single clock mode.
// [RQ8] the negative echo clock follows the negative output clock, or the negative input clock in single clock mode.
// [RQ9] a low dll disable input turns the delay-lock loop off.
// [RQ10] single clock mode is strapped by both output clocks high at power-on and never changes; the code recaptures it after each reset.
module dsr_core (
    input  wire logic                       ref_clk,       // block clock
    input  wire logic                       rst_b,         // sync reset
    input  wire logic                       in_clk_p,      // positive input clock
    input  wire logic                       in_clk_n,      // negative input clock
    input  wire logic                       out_clk_p,     // positive output clock
    input  wire logic                       out_clk_n,     // negative output clock
    input  wire logic                       load_strobe_n, // load strobe
    input  wire logic                       rw_sel,        // 1 read, 0 write
    input  wire logic [dsr_pkg::ADDR_W-1:0] addr,          // address
    input  wire logic [dsr_pkg::DATA_W-1:0] wdata,         // write data
    input  wire logic                       dll_disable_n, // dll off when low
    output logic [dsr_pkg::DATA_W-1:0]      rdata,         // read data pins
    output logic                            rdata_oe,      // read data driven
    output logic                            echo_clock_p,  // positive echo
    output logic                            echo_clock_n,  // negative echo
    output logic                            dll_on,        // dll running
    output logic                            single_clk,    // strapped mode
    input  wire logic                       rd_ready,      // beat sink ready
    output logic                            rd_stall       // buffer full
);
    // ------------------------------------------------------------------
    // pin synchronisers: two flops before any logic
    // ------------------------------------------------------------------
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [dsr_pkg::ADDR_W-1:0] addr_s1;
    logic [dsr_pkg::ADDR_W-1:0] addr_s2;
    logic [dsr_pkg::DATA_W-1:0] wd_s1;
    logic [dsr_pkg::DATA_W-1:0] wd_s2;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {in_clk_p, in_clk_n, out_clk_p, out_clk_n,
                      load_strobe_n, rw_sel, dll_disable_n, rd_ready,
                      1'b0};
            sync2 <= sync1;
        end
    end

    // addr and data carry no reset; they are read only beside a qualified edge
    always_ff @(posedge ref_clk) begin
        addr_s1 <= addr;
        addr_s2 <= addr_s1;
        wd_s1   <= wdata;
        wd_s2   <= wd_s1;
    end

    logic kp;
    logic kn;
    logic cp;
    logic cn;
    logic ld_n;
    logic rw;
    logic dll_disable_n_n;
    logic sink_rdy;
    assign {kp, kn, cp, cn, ld_n, rw, dll_disable_n_n, sink_rdy} = sync2[NSYNC-1:1];

    // ------------------------------------------------------------------
    // edge detection on the synchronised clocks
    // ------------------------------------------------------------------
    logic kp_d;
    logic kn_d;
    logic cp_d;
    logic cn_d;
    logic started;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            {kp_d, kn_d, cp_d, cn_d} <= 4'h0;
        end else begin
            {kp_d, kn_d, cp_d, cn_d} <= {kp, kn, cp, cn};
        end
    end

    // rises are seen on ref_clk, so a pin level must hold a few cycles
    logic kp_rise;
    logic kn_rise;
    logic cp_rise;
    logic cn_rise;
    assign kp_rise = kp && !kp_d;
    assign kn_rise = kn && !kn_d;
    assign cp_rise = cp && !cp_d;
    assign cn_rise = cn && !cn_d;

    // ------------------------------------------------------------------
    // settling after reset release
    // ------------------------------------------------------------------
    // the synchronisers restart at zero, so the strap pins are trusted
    // only once their post-reset level has crossed both flops
    logic [1:0] settle;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            settle <= 2'h0;
        end else if (settle != dsr_pkg::STRAP_WAIT) begin
            settle <= settle + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // strap capture after reset release
    // ------------------------------------------------------------------
    // a clocked catch avoids loading a port under reset
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            started    <= 1'b0;
            single_clk <= 1'b0;
        end else if (!started && settle == dsr_pkg::STRAP_WAIT) begin
            started    <= 1'b1;
            single_clk <= cp && cn; // RQ10
        end
    end

    // launch edges follow the strapped clock pair
    logic launch_p;
    logic launch_n;
    assign launch_p = single_clk ? kp_rise : cp_rise; // RQ4
    assign launch_n = single_clk ? kn_rise : cn_rise; // RQ5

    // ------------------------------------------------------------------
    // echo clocks and dll
    // ------------------------------------------------------------------
    // the echoes trail the pin clocks by the synchroniser depth plus this register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            echo_clock_p <= 1'b0;
            echo_clock_n <= 1'b0;
        end else begin
            echo_clock_p <= single_clk ? kp : cp; // RQ7
            echo_clock_n <= single_clk ? kn : cn; // RQ8
        end
    end

    // only the enable is kept here; the delay line lies outside this block
    always_ff @(posedge ref_clk) begin
        if (!rst_b) dll_on <= 1'b0;
        else dll_on <= dll_disable_n_n; // RQ9
    end

    // ------------------------------------------------------------------
    // command capture and write burst
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WR0  = 3'b010,
        ST_WR1  = 3'b100
    } dsr_wr_e;
    dsr_wr_e wr_st;

    dsr_pkg::dsr_cmd_s cmd;
    logic [dsr_pkg::DATA_W-1:0] mem [dsr_pkg::MEM_DEPTH];
    logic [dsr_pkg::IDX_W-1:0]  widx;
    logic [dsr_pkg::IDX_W-1:0]  widx_odd;
    logic [dsr_pkg::DATA_W-1:0] wr_beat0;
    logic                       rd_req;
    logic                       new_cmd;

    // loads that land during a write burst are dropped
    assign new_cmd = started && kp_rise && !ld_n; // RQ3

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cmd    <= '0;
            rd_req <= 1'b0;
        end else begin
            rd_req <= 1'b0;
            if (new_cmd && wr_st == ST_IDLE) begin
                cmd.rd   <= rw; // RQ1
                cmd.addr <= addr_s2;
                rd_req   <= (rw == dsr_pkg::RW_READ); // RQ1
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wr_st <= ST_IDLE;
        end else begin
            case (wr_st)
                ST_IDLE:
                    if (new_cmd && rw != dsr_pkg::RW_READ) wr_st <= ST_WR0;
                ST_WR0:
                    if (kp_rise) wr_st <= ST_WR1; // RQ4
                ST_WR1:
                    if (kn_rise) wr_st <= ST_IDLE; // RQ5
                default:
                    wr_st <= ST_IDLE;
            endcase
        end
    end

    // two words per burst at an even/odd pair of slots
    assign widx     = {cmd.addr[dsr_pkg::IDX_W-2:0], 1'b0}; // RQ2
    assign widx_odd = {cmd.addr[dsr_pkg::IDX_W-2:0], 1'b1}; // RQ2

    // ------------------------------------------------------------------
    // array update
    // ------------------------------------------------------------------
    // beat0 waits beside the array so both words land on one edge
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wr_beat0 <= dsr_pkg::DATA_RST;
        end else if (wr_st == ST_WR0 && kp_rise) begin
            wr_beat0 <= wd_s2; // RQ4
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wr_st == ST_WR1 && kn_rise) begin
            mem[widx]     <= wr_beat0; // RQ2
            mem[widx_odd] <= wd_s2; // RQ5
        end
    end

    // ------------------------------------------------------------------
    // read path through the two-entry buffer
    // ------------------------------------------------------------------
    dsr_pkg::dsr_burst_s rd_word;
    dsr_pkg::dsr_burst_s out_word;
    dsr_pkg::dsr_burst_s out_word_hold;
    logic                buf_ready;
    logic                buf_valid;
    logic                take;

    assign rd_word.beat0 = mem[widx]; // RQ2
    assign rd_word.beat1 = mem[widx_odd];
    // a read that finds both entries taken is lost; rd_stall shows it
    assign rd_stall = !buf_ready;

    dsr_buf2 u_buf (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .in_valid  (rd_req),
        .in_ready  (buf_ready),
        .in_data   (rd_word),
        .out_valid (buf_valid),
        .out_ready (take),
        .out_data  (out_word)
    );

    typedef enum logic [2:0] {
        RD_IDLE  = 3'b001,
        RD_BEAT0 = 3'b010,
        RD_BEAT1 = 3'b100
    } dsr_rd_e;
    dsr_rd_e rd_st;

    // a burst leaves the buffer only when the sink is ready at a launch
    assign take = (rd_st == RD_IDLE) && buf_valid && sink_rdy && launch_p;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rd_st    <= RD_IDLE;
            rdata    <= dsr_pkg::DATA_RST;
            rdata_oe <= 1'b0;
        end else begin
            case (rd_st)
                RD_IDLE: begin
                    if (take) begin
                        rdata    <= out_word.beat0; // RQ6
                        rdata_oe <= 1'b1;
                        rd_st    <= RD_BEAT1;
                    end else if (launch_p) begin
                        rdata_oe <= 1'b0;
                    end
                end
                RD_BEAT1: begin
                    if (launch_n) begin
                        rdata <= out_word_hold.beat1; // RQ6
                        rd_st <= RD_IDLE;
                    end
                end
                default: rd_st <= RD_IDLE;
            endcase
        end
    end

    // the buffer pops at the launch of beat0, so beat1 is kept here
    always_ff @(posedge ref_clk) begin
        if (!rst_b) out_word_hold <= '0;
        else if (take) out_word_hold <= out_word;
    end
endmodule // dsr_core
`default_nettype wire

//--- tb/dsr_monitor.sv
// port checks for the burst sram control block
`timescale 1ns/1ps
`default_nettype none
module dsr_monitor (
    input wire logic                       ref_clk,       // block clock
    input wire logic                       rst_b,         // sync reset
    input wire logic                       in_clk_p,      // input clock
    input wire logic                       out_clk_p,     // output clock
    input wire logic                       out_clk_n,     // output clock
    input wire logic                       load_strobe_n, // load
    input wire logic                       rw_sel,        // read select
    input wire logic                       dll_disable_n, // dll off
    input wire logic [dsr_pkg::DATA_W-1:0] rdata,         // read data
    input wire logic                       rdata_oe,      // data driven
    input wire logic                       echo_clock_p,  // echo
    input wire logic                       echo_clock_n,  // echo
    input wire logic                       dll_on,        // dll state
    input wire logic                       single_clk     // strap
);
    logic [2:0] up;
    logic [7:0] since;
    logic       rd_seen;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge ref_clk) begin
        if (!rst_b || up == 3'h7) up <= rst_b ? up : 3'h0;
        else up <= up + 3'h1;
    end
    // either edge of the positive launch clock restarts the count; data may only move soon after
    always_ff @(posedge ref_clk) begin
        if (!rst_b || $changed(single_clk ? in_clk_p : out_clk_p)) since <= 8'h0;
        else if (since != 8'hff) since <= since + 8'h1;
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) rd_seen <= 1'b0;
        else if (!load_strobe_n && rw_sel) rd_seen <= 1'b1;
    end
    a_echo_rise: assert property (
        !single_clk && $rose(out_clk_p) |-> ##[1:6] echo_clock_p)
        else $error("echo_clock_p missed output clock rise");
    a_echo_neg: assert property (
        !single_clk && $rose(out_clk_n) |-> ##[1:6] echo_clock_n)
        else $error("echo_clock_n missed output clock rise");
    a_dll_off: assert property (
        !dll_disable_n [*6] |-> !dll_on) else $error("dll still on");
    a_dll_on: assert property (
        dll_disable_n [*6] |-> dll_on) else $error("dll still off");
    a_strap_fixed: assert property (
        up == 3'h7 |-> $stable(single_clk)) else $error("strap changed");
    a_oe_cause: assert property (
        $rose(rdata_oe) |-> rd_seen) else $error("data driven without read");
    a_burst_len: assert property (
        $rose(rdata_oe) |-> rdata_oe [*8]) else $error("burst cut short");
    a_data_launch: assert property (
        $changed(rdata) |-> since <= 8'h6) else $error("data off launch edge");
endmodule // dsr_monitor
bind dsr_core dsr_monitor u_mon (.*);
`default_nettype wire

//--- tb/dsr_ctl_model.sv
// controller model driving clocks, commands and write data
`timescale 1ns/1ps
`default_nettype none
module dsr_ctl_model (
    input  wire logic                     ref_clk,       // block clock
    input  wire logic                     single,        // strap mode
    output logic                          in_clk_p,      // input clock
    output logic                          in_clk_n,      // input clock
    output logic                          out_clk_p,     // output clock
    output logic                          out_clk_n,     // output clock
    output logic                          load_strobe_n, // load
    output logic                          rw_sel,        // read select
    output logic [dsr_pkg::ADDR_W-1:0]    addr,          // address
    output logic [dsr_pkg::DATA_W-1:0]    wdata          // write data
);
    dsr_pkg::dsr_cmd_s          cq[$];
    dsr_pkg::dsr_burst_s        dq[$];
    dsr_pkg::dsr_cmd_s          c;
    dsr_pkg::dsr_burst_s        d;
    logic [4:0]                 cyc;
    logic [1:0]                 wst;
    logic [dsr_pkg::DATA_W-1:0] w1;
    task automatic put(input dsr_pkg::dsr_cmd_s nc, input dsr_pkg::dsr_burst_s nd);
        cq.push_back(nc);
        dq.push_back(nd);
    endtask
    initial begin
        {cyc, wst, in_clk_p, out_clk_p, rw_sel, addr, wdata} = '0;
        {in_clk_n, out_clk_n, load_strobe_n} = 3'h7;
    end
    // output clocks lag by a quarter period so echo sources can be told apart
    always @(negedge ref_clk) begin
        cyc <= cyc + 5'h1;
        if (cyc == 5'h0) {in_clk_p, in_clk_n} <= 2'h2;
        if (cyc == 5'h10) {in_clk_p, in_clk_n} <= 2'h1;
        if (cyc == 5'h8) {out_clk_p, out_clk_n} <= {1'b1, single};
        if (cyc == 5'h18) {out_clk_p, out_clk_n} <= {single, 1'b1};
        if (cyc == 5'h8) begin
            load_strobe_n <= 1'b1;
            rw_sel <= ~rw_sel;
            addr <= ~addr;
            if (wst == 2'h1) wdata <= w1;
            if (wst != 2'h0) wst <= wst - 2'h1;
        end
        if (cyc == 5'h18 && wst == 2'h0) begin
            if (cq.size() != 0) begin
                c = cq.pop_front();
                d = dq.pop_front();
                {load_strobe_n, rw_sel, addr} <= {1'b0, c};
                wdata <= c.rd ? ~wdata : d.beat0;
                w1 <= d.beat1;
                wst <= c.rd ? 2'h0 : 2'h2;
            end else wdata <= ~wdata;
        end
    end
endmodule // dsr_ctl_model
`default_nettype wire

//--- tb/test_ddr_sio_sram_clock_control_pins.sv
// self-checking bench for the burst sram control block
`timescale 1ns/1ps
`default_nettype none
module test_ddr_sio_sram_clock_control_pins;
    logic                       ref_clk, rst_b, single, in_clk_p, in_clk_n;
    logic                       out_clk_p, out_clk_n, load_strobe_n, rw_sel;
    logic                       dll_disable_n, rd_ready, rdata_oe, rd_stall;
    logic                       echo_clock_p, echo_clock_n, dll_on, single_clk;
    logic [dsr_pkg::ADDR_W-1:0] addr;
    logic [dsr_pkg::DATA_W-1:0] wdata, rdata;
    logic [dsr_pkg::DATA_W-1:0] got[$];
    logic [dsr_pkg::DATA_W-1:0] ex[4];
    dsr_pkg::dsr_burst_s        mem[8];
    int                         failures, checked, cycles;
    dsr_core dut (.*);
    dsr_ctl_model m (.*);
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // beats are taken seven cycles into each launch phase, once they have settled
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 10000) begin
            failures++;
            results();
        end else if (rst_b && rdata_oe
                     && m.cyc[3:0] == (single ? 4'h7 : 4'hf)) begin
            got.push_back(rdata);
        end
    end
    task automatic chk_w(string n, logic [17:0] e, logic [17:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_b(string n, logic e, logic g);
        chk_w(n, {17'h0, e}, {17'h0, g});
    endtask
    task automatic results;
        if (failures == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic put(logic rd, logic [2:0] i);
        m.put('{rd, {17'h0, i}}, mem[i]);
    endtask
    task automatic drain;
        for (int k = 0; k < 2000 && (m.cq.size() != 0 || m.wst != 0); k++)
            @(negedge ref_clk);
        repeat (160) @(negedge ref_clk);
    endtask
    task automatic at_cyc(logic [4:0] v);
        for (int k = 0; k < 40 && m.cyc !== v; k++) @(posedge ref_clk);
    endtask
    task automatic t_mode(logic s);
        chk_b("single_clk", s, single_clk);
        at_cyc(5'h7);
        chk_b("echo_clock_p", s, echo_clock_p);
        chk_b("echo_clock_n", !s, echo_clock_n);
        at_cyc(5'h17);
        chk_b("echo_clock_p", !s, echo_clock_p);
        chk_b("echo_clock_n", s, echo_clock_n);
    endtask
    task automatic t_rw(logic [17:0] base);
        mem[0] = '{base ^ 18'h3ffff, base};
        mem[7] = '{base + 18'h00107, base + 18'h00007};
        put(1'b0, 3'h0);
        put(1'b0, 3'h7);
        put(1'b1, 3'h7);
        put(1'b1, 3'h0);
        got.delete();
        drain();
        ex = '{mem[7].beat0, mem[7].beat1, mem[0].beat0, mem[0].beat1};
        chk_w("beat count", 18'h4, 18'(got.size()));
        for (int j = 0; j < 4; j++) chk_w("read beat", ex[j], got[j]);
    endtask
    task automatic t_stall;
        rd_ready = 1'b0;
        got.delete();
        repeat (3) put(1'b1, 3'h0);
        drain();
        chk_b("rd_stall", 1'b1, rd_stall);
        chk_w("beats held", 18'h0, 18'(got.size()));
        rd_ready = 1'b1;
        drain();
        chk_w("beats after stall", 18'h4, 18'(got.size()));
        chk_w("held beat", mem[0].beat1, got[3]);
    endtask
    task automatic t_dll;
        dll_disable_n = 1'b0;
        repeat (10) @(negedge ref_clk);
        chk_b("dll_on", 1'b0, dll_on);
        dll_disable_n = 1'b1;
        repeat (10) @(negedge ref_clk);
        chk_b("dll_on", 1'b1, dll_on);
    endtask
    initial begin
        {single, rst_b, failures, checked, cycles} = '0;
        {dll_disable_n, rd_ready} = 2'h3;
        repeat (10) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (40) @(negedge ref_clk);
        t_mode(1'b0);
        t_rw(18'h2a5a5);
        t_stall();
        t_dll();
        single = 1'b1;
        repeat (32) @(negedge ref_clk);
        rst_b = 1'b0;
        repeat (10) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (40) @(negedge ref_clk);
        t_mode(1'b1);
        t_rw(18'h15a5a);
        results();
    end
endmodule // test_ddr_sio_sram_clock_control_pins
`default_nettype wire
